// ===== rtl/ebc_top.sv
`timescale 1ns/1ps
module ebc_top
	import ebc_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [PADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// CPU core side
	input wire logic XMOVE_REQ,
	input wire logic XMOVE_WRITE,
	input wire logic CODE_MOVE,
	input wire logic EXT_FETCH,
	input wire logic DOUBLE_SPEED,
	input wire logic SECURITY_EXT_MEM,
	output logic XRAM_HIT,
	output logic XMOVE_BUSY,
	output logic EXT_SELECT,
	output logic [9:0] XRAM_LAST_ADDR,
	// External memory pins
	output logic ALE_O,
	output logic ALE_OE,
	output logic ALE_PULLUP,
	output logic RD_N,
	output logic WR_N
);

	logic [7:0] aux;
	logic [7:0] next_aux;
	logic loaded;
	logic next_loaded;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [9:0] next_last;
	logic addr_hit;
	logic setup;
	logic wr_take;

	assign addr_hit = PADDR == AUX_ADDR;
	assign setup = PSEL && !PENABLE;
	assign wr_take = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
	assign EXT_SELECT = aux[EXTSEL_BIT];

	// Register and APB slave
	always_comb
	begin
		next_aux = aux;
		next_loaded = 1'b1;
		if (!loaded)
			next_aux[EXTSEL_BIT] = SECURITY_EXT_MEM;
		else if (wr_take)
			next_aux = PWDATA[7:0] & AUX_WMASK;
		next_pready = setup;
		next_pslverr = setup && !addr_hit;
		next_prdata = 32'h0;
		if (setup && !PWRITE && addr_hit)
			next_prdata = {24'h0, aux};
		case ({aux[SIZE_HI_BIT], aux[SIZE_LO_BIT]})
			2'b00: next_last = XRAM_LAST_256;
			2'b01: next_last = XRAM_LAST_512;
			2'b10: next_last = XRAM_LAST_768;
			default: next_last = XRAM_LAST_1024;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			aux <= AUX_RST;
			loaded <= 1'b0;
			PRDATA <= 32'h0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			XRAM_LAST_ADDR <= XRAM_LAST_256;
		end
		else
		begin
			aux <= next_aux;
			loaded <= next_loaded;
			PRDATA <= next_prdata;
			PREADY <= next_pready;
			PSLVERR <= next_pslverr;
			XRAM_LAST_ADDR <= next_last;
		end
	end

	// Read and write strobe sequencer
	ebc_state_e state;
	ebc_state_e next_state;
	logic [4:0] scnt;
	logic [4:0] next_scnt;
	logic next_rd_n;
	logic next_wr_n;
	logic next_hit;
	logic strb_long;
	logic next_strb_long;

	always_comb
	begin
		next_state = state;
		next_scnt = scnt;
		next_rd_n = RD_N;
		next_wr_n = WR_N;
		next_hit = 1'b0;
		next_strb_long = strb_long;
		case (state)
			ST_IDLE:
				if (XMOVE_REQ)
				begin
					if (aux[EXTSEL_BIT])
					begin
						next_state = ST_STROBE;
						next_strb_long = aux[STRETCH_BIT];
						next_scnt = aux[STRETCH_BIT] ? STRB_LONG - 5'h1
							: STRB_SHORT - 5'h1;
						next_rd_n = XMOVE_WRITE;
						next_wr_n = !XMOVE_WRITE;
					end
					else
						next_hit = 1'b1;
				end
			ST_STROBE:
				if (scnt == 5'h0)
				begin
					next_state = ST_IDLE;
					next_rd_n = 1'b1;
					next_wr_n = 1'b1;
				end
				else
					next_scnt = scnt - 5'h1;
			default:
			begin
				next_state = ST_IDLE;
				next_rd_n = 1'b1;
				next_wr_n = 1'b1;
			end
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			state <= ST_IDLE;
			scnt <= 5'h0;
			RD_N <= 1'b1;
			WR_N <= 1'b1;
			XRAM_HIT <= 1'b0;
			XMOVE_BUSY <= 1'b0;
			strb_long <= 1'b0;
		end
		else
		begin
			state <= next_state;
			scnt <= next_scnt;
			RD_N <= next_rd_n;
			WR_N <= next_wr_n;
			XRAM_HIT <= next_hit;
			XMOVE_BUSY <= next_state != ST_IDLE;
			strb_long <= next_strb_long;
		end
	end

	// Address latch strobe generator
	logic [2:0] acnt;
	logic [2:0] next_acnt;
	logic [2:0] div;
	logic activity;
	logic allow;
	logic next_ale;

	always_comb
	begin
		div = DOUBLE_SPEED ? ALE_DIV_FAST : ALE_DIV_STD;
		next_acnt = (acnt >= div - 3'h1) ? 3'h0 : acnt + 3'h1;
		activity = XMOVE_BUSY || XMOVE_REQ || CODE_MOVE || EXT_FETCH;
		allow = !aux[SUPPRESS_BIT] || activity;
		next_ale = (acnt == 3'h0) && allow;
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			acnt <= 3'h0;
			ALE_O <= 1'b0;
			ALE_OE <= 1'b1;
			ALE_PULLUP <= 1'b0;
		end
		else
		begin
			acnt <= next_acnt;
			ALE_O <= next_ale;
			ALE_OE <= allow;
			ALE_PULLUP <= !allow;
		end
	end

	// Checks
	logic [4:0] lo_cnt;

	always_ff @(posedge CLK)
	begin
		if (SRST || (RD_N && WR_N))
			lo_cnt <= 5'h0;
		else
			lo_cnt <= lo_cnt + 5'h1;
	end

	logic norm6;
	logic norm3;
	assign norm6 = !aux[SUPPRESS_BIT] && !DOUBLE_SPEED;
	assign norm3 = !aux[SUPPRESS_BIT] && DOUBLE_SPEED;

	sequence s_ale6;
		(ALE_O && norm6) ##1 norm6[*5];
	endsequence

	sequence s_ale3;
		(ALE_O && norm3) ##1 norm3[*2];
	endsequence

	property p_ale_std;
		@(posedge CLK) disable iff (SRST)
		s_ale6 |=> ALE_O && $past(!ALE_O);
	endproperty
	a_ale_std: assert property (p_ale_std) else $error("ale period not 6");

	property p_ale_x2;
		@(posedge CLK) disable iff (SRST)
		s_ale3 |=> ALE_O && $past(!ALE_O);
	endproperty
	a_ale_x2: assert property (p_ale_x2) else $error("ale period not 3");

	property p_ale_quiet;
		@(posedge CLK) disable iff (SRST)
		aux[SUPPRESS_BIT] && !activity |=> !ALE_OE && !ALE_O;
	endproperty
	a_ale_quiet: assert property (p_ale_quiet) else $error("ale not off");

	property p_ale_active;
		@(posedge CLK) disable iff (SRST)
		(CODE_MOVE || EXT_FETCH) |=> ALE_OE;
	endproperty
	a_ale_active: assert property (p_ale_active) else $error("ale lost");

	property p_ale_pull;
		@(posedge CLK) disable iff (SRST)
		ALE_OE != ALE_PULLUP;
	endproperty
	a_ale_pull: assert property (p_ale_pull) else $error("pull wrong");

	property p_strb_len;
		@(posedge CLK) disable iff (SRST)
		$rose(RD_N && WR_N) |-> lo_cnt == (strb_long ? 5'h1e : 5'h06);
	endproperty
	a_strb_len: assert property (p_strb_len) else $error("strobe length");

	property p_size;
		@(posedge CLK) disable iff (SRST)
		$past(aux[SIZE_HI_BIT:SIZE_LO_BIT]) == 2'b01 |-> XRAM_LAST_ADDR == 10'h1ff;
	endproperty
	a_size: assert property (p_size) else $error("size 512 wrong");

	property p_size_max;
		@(posedge CLK) disable iff (SRST)
		$past(aux[SIZE_HI_BIT:SIZE_LO_BIT]) == 2'b11 |-> XRAM_LAST_ADDR == 10'h3ff;
	endproperty
	a_size_max: assert property (p_size_max) else $error("size 1024 wrong");

	property p_route;
		@(posedge CLK) disable iff (SRST)
		XMOVE_REQ && !XMOVE_BUSY && !aux[EXTSEL_BIT] |=> XRAM_HIT && RD_N && WR_N;
	endproperty
	a_route: assert property (p_route) else $error("route internal");

	property p_strap;
		@(posedge CLK) disable iff (SRST)
		$fell(SRST) |=> aux[EXTSEL_BIT] == $past(SECURITY_EXT_MEM);
	endproperty
	a_strap: assert property (p_strap) else $error("strap not loaded");

endmodule

// ===== rtl/ebc_pkg.sv
package ebc_pkg;

	// Register map
	localparam int PADDR_W = 12;
	localparam logic [PADDR_W-1:0] AUX_IDX = 12'h08e;
	localparam logic [PADDR_W-1:0] AUX_ADDR = AUX_IDX << 2;
	localparam logic [7:0] AUX_RST = 8'h00;
	localparam logic [7:0] AUX_WMASK = 8'h2f;

	// Field positions of the auxiliary register
	localparam int SUPPRESS_BIT = 0;
	localparam int EXTSEL_BIT = 1;
	localparam int SIZE_LO_BIT = 2;
	localparam int SIZE_HI_BIT = 3;
	localparam int STRETCH_BIT = 5;

	// Address latch strobe period in oscillator cycles
	localparam logic [2:0] ALE_DIV_STD = 3'h6;
	localparam logic [2:0] ALE_DIV_FAST = 3'h3;

	// Read and write strobe length in clock periods
	localparam logic [4:0] STRB_SHORT = 5'h06;
	localparam logic [4:0] STRB_LONG = 5'h1e;

	// Last on-chip extended RAM address per size code
	localparam logic [9:0] XRAM_LAST_256 = 10'h0ff;
	localparam logic [9:0] XRAM_LAST_512 = 10'h1ff;
	localparam logic [9:0] XRAM_LAST_768 = 10'h2ff;
	localparam logic [9:0] XRAM_LAST_1024 = 10'h3ff;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_STROBE = 2'b01
	} ebc_state_e;

endpackage

// ===== tb/ebc_xmem.sv
`timescale 1ns/1ps
module ebc_xmem
(
	// Strobes from the block
	input wire logic clk,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic ale_o,
	input wire logic ale_oe,
	input wire logic ale_pu,
	// Seen by the memory
	output logic ale_pin,
	output logic [7:0] strb_len
);
	logic [7:0] cnt = 8'h00;
	// Released pin floats to the pull level
	assign ale_pin = ale_oe ? ale_o : ale_pu;
	initial strb_len = 8'h00;
	// Length of the last read or write strobe
	always @(posedge clk)
	begin
		if (!rd_n || !wr_n)
			cnt <= cnt + 8'h01;
		else if (cnt != 8'h00)
		begin
			strb_len <= cnt;
			cnt <= 8'h00;
		end
	end
endmodule

// ===== tb/ebc_top_tb.sv
`timescale 1ns/1ps
module ebc_top_tb
	import ebc_pkg::*;
;
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, e, xreq = 0, xwr = 0, cmove = 0;
	logic xfetch = 0, dspeed = 0, strap = 0, hit, busy, extsel;
	logic [9:0] last;
	logic ale_o, ale_oe, ale_pu, rd_n, wr_n, pin;
	logic [7:0] slen;
	int fail_count = 0;
	int tests_run = 0;
	int c;
	always #4 clk = ~clk;
	ebc_top i_ebc_top (.CLK(clk), .SRST(srst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .XMOVE_REQ(xreq), .XMOVE_WRITE(xwr),
		.CODE_MOVE(cmove), .EXT_FETCH(xfetch), .DOUBLE_SPEED(dspeed),
		.SECURITY_EXT_MEM(strap), .XRAM_HIT(hit), .XMOVE_BUSY(busy),
		.EXT_SELECT(extsel), .XRAM_LAST_ADDR(last), .ALE_O(ale_o),
		.ALE_OE(ale_oe), .ALE_PULLUP(ale_pu), .RD_N(rd_n), .WR_N(wr_n));
	ebc_xmem i_ebc_xmem (.clk(clk), .rd_n(rd_n), .wr_n(wr_n),
		.ale_o(ale_o), .ale_oe(ale_oe), .ale_pu(ale_pu), .ale_pin(pin),
		.strb_len(slen));
	task results;
		$display("tests %0d fails %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [32:0] got, input logic [32:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			fail_count++;
			results;
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task ale(input int n);
		c = 0;
		repeat (n)
		begin
			@(posedge clk);
			c += int'(pin);
		end
	endtask
	task move(input logic w, input logic ext, input logic [7:0] len);
		int n;
		n = 0;
		@(posedge clk);
		xreq <= 1;
		xwr <= w;
		@(posedge clk);
		xreq <= 0;
		@(posedge clk);
		chk(hit, !ext);
		chk({rd_n, wr_n}, ext ? {w, !w} : 2'b11);
		chk(ale_oe, 1);
		chk(busy, ext);
		while (busy !== 1'b0 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		if (busy !== 1'b0)
		begin
			fail_count++;
			results;
		end
		repeat (2) @(posedge clk);
		if (ext)
			chk(slen, len);
	endtask
	task t_regs;
		apb(0, AUX_ADDR, 0);
		chk({e, r}, 0);
		apb(0, 12'h000, 0);
		chk({e, r}, 33'h100000000);
		apb(1, AUX_ADDR, 32'h2f);
		apb(0, AUX_ADDR, 0);
		chk(r, 32'h2f);
		strap <= 1;
		srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		repeat (3) @(posedge clk);
		chk(extsel, 1);
		strap <= 0;
		$display("regs done");
	endtask
	task t_size;
		for (int i = 0; i < 4; i++)
		begin
			apb(1, AUX_ADDR, i << 2);
			repeat (2) @(posedge clk);
			chk(last, {i[1:0], 8'hff});
		end
		$display("size done");
	endtask
	task t_ale;
		apb(1, AUX_ADDR, 0);
		ale(24);
		chk(c, 4);
		dspeed <= 1;
		repeat (6) @(posedge clk);
		ale(24);
		chk(c, 8);
		dspeed <= 0;
		apb(1, AUX_ADDR, 1);
		repeat (3) @(posedge clk);
		ale(12);
		chk(c, 12);
		chk({ale_oe, ale_o, pin}, 3'b001);
		for (int k = 0; k < 2; k++)
		begin
			cmove <= k == 0;
			xfetch <= k == 1;
			repeat (8) @(posedge clk);
			ale(12);
			chk({c, ale_oe}, 5);
		end
		xfetch <= 0;
		$display("ale done");
	endtask
	task t_move;
		apb(1, AUX_ADDR, 3);
		move(0, 1, 6);
		apb(1, AUX_ADDR, 32'h23);
		move(1, 1, 30);
		apb(1, AUX_ADDR, 1);
		move(0, 0, 0);
		$display("move done");
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 0;
		t_regs;
		t_size;
		t_ale;
		t_move;
		results;
	end
endmodule
